// file: bench/fsp_core_model.sv
/*
 * behavioural processor core running the self-program sequence.
 * assumes the sequencer samples every input on the rising clock edge.
 */
`timescale 1ns/1ns
module fsp_core_model
    import fsp_pkg::*;
(
    input wire logic clk,
    input wire logic core_stall,
    output logic [6:0] nv_addr_high,
    output logic [7:0] nv_addr_low,
    output logic [5:0] nv_data_high,
    output logic [7:0] nv_data_low,
    output logic key_wr,
    output logic [7:0] key_data,
    output logic trig_wr,
    output logic row_erase_wr,
    output logic row_erase_wdata,
    output logic config_space_select,
    output logic program_memory_select,
    output logic program_write_enable,
    output logic latches_only_load
);
    // idle levels from time zero
    initial begin
        {nv_addr_high, nv_addr_low, nv_data_high, nv_data_low} = 29'h0;
        {key_wr, key_data, trig_wr, row_erase_wr, row_erase_wdata} = 12'h0;
        {config_space_select, program_memory_select} = 2'h0;
        {program_write_enable, latches_only_load} = 2'h0;
    end

    // ctl = {row erase, latches only, write enable, program memory, config space}
    // selects, keys, trigger
    task automatic issue(input logic [14:0] addr, input logic [13:0] data,
                         input logic [4:0] ctl, input logic [7:0] k1, input logic [7:0] k2);
        // a halted core issues nothing
        while (core_stall === 1'b1) @(posedge clk);
        @(posedge clk);
        {nv_addr_high, nv_addr_low} <= addr;
        {nv_data_high, nv_data_low} <= data;
        {latches_only_load, program_write_enable, program_memory_select} <= ctl[3:1];
        config_space_select <= ctl[0];
        row_erase_wr <= 1'b1;
        row_erase_wdata <= ctl[4];
        @(posedge clk);
        row_erase_wr <= 1'b0;
        key_wr <= 1'b1;
        key_data <= k1;
        @(posedge clk);
        key_data <= k2;
        @(posedge clk);
        key_wr <= 1'b0;
        trig_wr <= 1'b1;
        @(posedge clk);
        trig_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : issue
endmodule : fsp_core_model

// file: bench/tb_fsp_sequencer.sv
/*
 * self-checking bench: refused triggers, row erase, latch loads, programs.
 * assumes short erase and program counts set by parameter below.
 */
`timescale 1ns/1ns
module tb_fsp_sequencer
    import fsp_pkg::*;
;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int LAT = 8;
    localparam int ERASE_N = 30;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] nv_addr_high;
    logic [7:0] nv_addr_low, nv_data_low, key_data;
    logic [5:0] nv_data_high;
    logic key_wr, trig_wr, row_erase_wr, row_erase_wdata, config_space_select;
    logic program_memory_select, program_write_enable, latches_only_load;
    logic trigger_bit, row_erase_bit, core_stall, flash_erase_en, flash_wr_en;
    logic [ADDR_W-1:0] flash_addr, erase_addr;
    logic [DATA_W-1:0] flash_wdata;
    logic [ADDR_W-1:0] wr_addr [$];
    logic [DATA_W-1:0] wr_data [$];
    int fail_count = 0, samples_checked = 0, stall_cnt, trig_cnt, erase_cnt;

    fsp_sequencer #(.LATCHES(LAT), .ROW_WORDS(32), .ERASE_CYCLES(ERASE_N), .PROG_CYCLES(20)) DUT (
        .clk(clk), .rst_b(rst_b), .nv_addr_high(nv_addr_high), .nv_addr_low(nv_addr_low),
        .nv_data_high(nv_data_high), .nv_data_low(nv_data_low), .key_wr(key_wr),
        .key_data(key_data), .trig_wr(trig_wr), .row_erase_wr(row_erase_wr),
        .row_erase_wdata(row_erase_wdata), .config_space_select(config_space_select),
        .program_memory_select(program_memory_select), .latches_only_load(latches_only_load),
        .program_write_enable(program_write_enable), .trigger_bit(trigger_bit),
        .row_erase_bit(row_erase_bit), .core_stall(core_stall), .flash_erase_en(flash_erase_en),
        .flash_wr_en(flash_wr_en), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
    fsp_core_model u_core (
        .clk(clk), .core_stall(core_stall), .nv_addr_high(nv_addr_high),
        .nv_addr_low(nv_addr_low), .nv_data_high(nv_data_high), .nv_data_low(nv_data_low),
        .key_wr(key_wr), .key_data(key_data), .trig_wr(trig_wr), .row_erase_wr(row_erase_wr),
        .row_erase_wdata(row_erase_wdata), .config_space_select(config_space_select),
        .program_memory_select(program_memory_select), .latches_only_load(latches_only_load),
        .program_write_enable(program_write_enable));

    // free-running system clock
    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // flash side monitor: stands in for the array, counts busy cycles
    always @(posedge clk) begin
        if (flash_wr_en === 1'b1) begin
            wr_addr.push_back(flash_addr);
            wr_data.push_back(flash_wdata);
        end
        if (flash_erase_en === 1'b1) begin
            erase_cnt++;
            erase_addr = flash_addr;
        end
        if (core_stall === 1'b1) stall_cnt++;
        if (trigger_bit === 1'b1) trig_cnt++;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // off-edge so the monitor never races the clearing
    task automatic clear();
        #1;
        wr_addr.delete();
        wr_data.delete();
        {stall_cnt, trig_cnt, erase_cnt} = {32'h0, 32'h0, 32'h0};
    endtask : clear

    task automatic wait_idle();
        int n;
        n = 0;
        #1;
        while (trigger_bit !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(32'(n >= 300), 32'h0);
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_idle

    task automatic check_block(input logic [14:0] base, input int nload, input int fin,
                               input logic [13:0] fdata);
        check(wr_addr.size(), LAT);
        check(erase_cnt, 0);
        for (int i = 0; i < LAT; i++) begin
            check(wr_addr[i], base + 15'(i));
            check(wr_data[i], i == fin ? fdata : (i < nload ? 14'h0A01 + 14'(i) : ERASED_WORD));
        end
    endtask : check_block

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic scen_refuse();
        logic [20:0] cases [5];
        cases = '{{5'h06, 8'hAA, 8'h55}, {5'h06, 8'h55, 8'h55}, {5'h02, 8'h55, 8'hAA},
                  {5'h04, 8'h55, 8'hAA}, {5'h07, 8'h55, 8'hAA}};
        foreach (cases[i]) begin
            clear();
            u_core.issue(15'h0100, 14'h0123, cases[i][20:16], cases[i][15:8], cases[i][7:0]);
            repeat (3) @(posedge clk);
            #1;
            check(trig_cnt, 0);
            check(stall_cnt + wr_addr.size() + erase_cnt, 0);
        end
    endtask : scen_refuse

    task automatic scen_erase();
        clear();
        // latches-only left set as well: the erase select must still win
        u_core.issue(15'h0123, 14'h0000, 5'h1E, KEY_FIRST, KEY_SECOND);
        #1;
        check(core_stall, 1);
        check(row_erase_bit, 1);
        wait_idle();
        check(erase_cnt, 1);
        check(erase_addr, 15'h0120);
        check(stall_cnt, ERASE_N);
        check(trig_cnt, ERASE_N + 2);
        check(row_erase_bit, 0);
        check(wr_addr.size(), 0);
    endtask : scen_erase

    task automatic scen_program();
        clear();
        for (int i = 0; i < 3; i++) begin
            u_core.issue(15'h0208 + 15'(i), 14'h0A01 + 14'(i), 5'h0E, KEY_FIRST, KEY_SECOND);
            wait_idle();
        end
        check(trig_cnt, 6);
        check(stall_cnt + wr_addr.size(), 0);
        u_core.issue(15'h020F, 14'h2ABC, 5'h06, KEY_FIRST, KEY_SECOND);
        #1;
        check(core_stall, 1);
        wait_idle();
        check_block(15'h0208, 3, 7, 14'h2ABC);
        // back to back: nothing loaded but the final word
        clear();
        u_core.issue(15'h0533, 14'h0155, 5'h06, KEY_FIRST, KEY_SECOND);
        wait_idle();
        check_block(15'h0530, 0, 3, 14'h0155);
    endtask : scen_program

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check({trigger_bit, row_erase_bit, core_stall, flash_erase_en, flash_wr_en}, 5'h00);
        scen_refuse();
        scen_erase();
        scen_program();
        close_out();
    end

    // tests need about two hundred cycles; twenty times that means a hang
    initial begin
        #(CLK_PERIOD_NS * 4000);
        fail_count++;
        close_out();
    end
endmodule : tb_fsp_sequencer

// file: core/fsp_latch_bank.sv
/*
 * write latch bank: one word per latch, loaded singly, read by index,
 * all reset to the erased word together.
 * assumes index and strobes come from logic on the same clock.
 */
`timescale 1ns/1ns
module fsp_latch_bank
    import fsp_pkg::*;
#(
    parameter int LATCHES = 8,
    parameter int LAT_BITS = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ld_en,
    input wire logic [LAT_BITS-1:0] ld_idx,
    input wire logic [DATA_W-1:0] ld_data,
    input wire logic clr_all,
    input wire logic [LAT_BITS-1:0] rd_idx,
    output logic [DATA_W-1:0] rd_data
);
    typedef struct packed {
        logic [LATCHES-1:0][DATA_W-1:0] word;
    } fsp_bank_t;

    fsp_bank_t q;
    fsp_bank_t d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // clear wins over a load; both never come in one cycle anyway
    always_comb begin
        d = q;
        if (ld_en) begin
            d.word[ld_idx] = ld_data;
        end
        if (clr_all) begin
            for (int i = 0; i < LATCHES; i++) begin
                d.word[i] = ERASED_WORD;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= {LATCHES{ERASED_WORD}};
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.word[rd_idx];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_latch_cleared: assert property (@(posedge clk) disable iff (!rst_b)
        clr_all |=> (q == {LATCHES{ERASED_WORD}}))
        else $error("latches not erased after program");
endmodule : fsp_latch_bank

// file: core/fsp_sequencer.sv
/*
 * flash self-program sequencer: unlock keys, row erase, latch loads
 * and whole-block program, with core stall during erase and program.
 * assumes software writes arrive as one-cycle strobes on the same clock
 * and that a flash array outside takes erase and word-write strobes.
 */
`timescale 1ns/1ns
//
// Function
// - erase only whole rows while running
// - row-erase bit readable until erase ends
// - two setup cycles after trigger
// - stall core about 2 ms erasing
// - resume at third instruction after trigger
// - program never erases anything itself
// - program writes at most latch count words
// - latch block aligned, never crosses boundary
// - latches reset to 3FFF after program
// - latches-only trigger just loads one latch
// - normal trigger loads last latch, programs
// - whole latch block written, loaded or not
// - latch load and program need keys
module fsp_sequencer
    import fsp_pkg::*;
#(
    parameter int LATCHES = 8,
    parameter int ROW_WORDS = 32,
    parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [6:0] nv_addr_high,
    input wire logic [7:0] nv_addr_low,
    input wire logic [5:0] nv_data_high,
    input wire logic [7:0] nv_data_low,
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    input wire logic trig_wr,
    input wire logic row_erase_wr,
    input wire logic row_erase_wdata,
    input wire logic config_space_select,
    input wire logic program_memory_select,
    input wire logic program_write_enable,
    input wire logic latches_only_load,
    output logic trigger_bit,
    output logic row_erase_bit,
    output logic core_stall,
    output logic flash_erase_en,
    output logic flash_wr_en,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] flash_wdata
);
    localparam int LAT_BITS = $clog2(LATCHES);
    localparam int ROW_BITS = $clog2(ROW_WORDS);

    typedef struct packed {
        fsp_state_t st;
        logic [1:0] key;
        logic [1:0] op;
        logic trig;
        logic free;
        logic stall;
        logic [CNT_W-1:0] cnt;
        logic [LAT_BITS-1:0] idx;
        logic [ADDR_W-LAT_BITS-1:0] base;
        logic erase_en;
        logic wr_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fsp_main_t;

    fsp_main_t q;
    fsp_main_t d;
    logic [ADDR_W-1:0] nv_addr;
    logic [DATA_W-1:0] nv_data;
    logic unlocked;
    logic setup_end;
    logic ld_en;
    logic clr_all;
    logic [DATA_W-1:0] rd_data;

    assign nv_addr = {nv_addr_high, nv_addr_low};
    assign nv_data = {nv_data_high, nv_data_low};
    assign unlocked = (q.key == KEY_BOTH) && program_write_enable;
    assign setup_end = (q.st == ST_SETUP) && (q.cnt == '0);
    assign ld_en = setup_end && (q.op != OP_ERASE);
    assign clr_all = (q.st == ST_WAIT) && (q.cnt == '0);

    fsp_latch_bank #(
        .LATCHES(LATCHES),
        .LAT_BITS(LAT_BITS)
    ) u_latch (
        .clk(clk),
        .rst_b(rst_b),
        .ld_en(ld_en),
        .ld_idx(nv_addr[LAT_BITS-1:0]),
        .ld_data(nv_data),
        .clr_all(clr_all),
        .rd_idx(q.idx),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.erase_en = 1'b0;
        d.wr_en = 1'b0;
        // any other write breaks the key sequence
        if (key_wr) begin
            if (key_data == KEY_FIRST) begin
                d.key = KEY_HALF;
            end else if (key_data == KEY_SECOND && q.key == KEY_HALF) begin
                d.key = KEY_BOTH;
            end else begin
                d.key = KEY_NONE;
            end
        end
        if (trig_wr || row_erase_wr) begin
            d.key = KEY_NONE;
        end
        // progress bit only writable while idle, hardware owns it later
        if (row_erase_wr && q.st == ST_IDLE) begin
            d.free = row_erase_wdata;
        end
        case (q.st)
            ST_IDLE: begin
                // config space is not this block's job, trigger dropped
                if (trig_wr && unlocked && program_memory_select && !config_space_select) begin
                    d.trig = 1'b1;
                    d.st = ST_SETUP;
                    d.cnt = CNT_W'(SETUP_CYCLES - 1);
                    if (q.free) begin
                        d.op = OP_ERASE;
                    end else if (latches_only_load) begin
                        d.op = OP_LOAD;
                    end else begin
                        d.op = OP_PROG;
                    end
                end
            end
            ST_SETUP: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == '0) begin
                    d.base = nv_addr[ADDR_W-1:LAT_BITS];
                    d.idx = '0;
                    if (q.op == OP_ERASE) begin
                        d.erase_en = 1'b1;
                        d.addr = {nv_addr[ADDR_W-1:ROW_BITS], {ROW_BITS{1'b0}}};
                        d.stall = 1'b1;
                        d.cnt = CNT_W'(ERASE_CYCLES - 1);
                        d.st = ST_ERASE;
                    end else if (q.op == OP_LOAD) begin
                        d.trig = 1'b0;
                        d.st = ST_IDLE;
                    end else begin
                        d.stall = 1'b1;
                        d.st = ST_PROG;
                    end
                end
            end
            ST_ERASE: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == '0) begin
                    // progress bit drops at the end
                    d.free = 1'b0;
                    d.trig = 1'b0;
                    d.stall = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            ST_PROG: begin
                d.erase_en = 1'b0;
                // every latch goes out, loaded or not
                d.wr_en = 1'b1;
                // address stays inside the latch block
                d.addr = {q.base, q.idx};
                d.wdata = rd_data;
                d.idx = q.idx + 1'b1;
                if (q.idx == LAT_BITS'(LATCHES - 1)) begin
                    d.cnt = CNT_W'(PROG_CYCLES - 1);
                    d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                d.cnt = q.cnt - 1'b1;
                if (q.cnt == '0) begin
                    d.trig = 1'b0;
                    d.stall = 1'b0;
                    d.st = ST_IDLE;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: ST_IDLE, key: KEY_NONE, op: OP_LOAD, default: '0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign trigger_bit = q.trig;
    assign row_erase_bit = q.free;
    assign core_stall = q.stall;
    assign flash_erase_en = q.erase_en;
    assign flash_wr_en = q.wr_en;
    assign flash_addr = q.addr;
    assign flash_wdata = q.wdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_trig_needs_keys: assert property (
        (trig_wr && q.key != KEY_BOTH && !q.trig) |=> !q.trig)
        else $error("trigger taken without unlock keys");
    a_setup_two_cycles: assert property (
        $rose(q.trig) |-> (!q.stall && !q.wr_en && !q.erase_en) [*2])
        else $error("operation started before two setup cycles");
    a_erase_row_only: assert property (
        flash_erase_en |-> (flash_addr[ROW_BITS-1:0] == '0))
        else $error("erase address not on a row boundary");
    a_erase_stalls: assert property (
        (setup_end && q.op == OP_ERASE) |=> core_stall [*8])
        else $error("core not stalled during erase");
    a_erase_done: assert property (
        ($fell(core_stall) && $past(q.st) == ST_ERASE) |-> (!row_erase_bit && !trigger_bit))
        else $error("row erase bit or trigger left set after erase");
    a_resume_idle: assert property (
        $fell(core_stall) |-> (q.st == ST_IDLE && !q.trig))
        else $error("core released while operation still running");
    a_load_only: assert property (
        (setup_end && q.op == OP_LOAD) |=> (q.st == ST_IDLE && !core_stall && !trigger_bit))
        else $error("latch-only trigger started a flash cycle");
    a_prog_starts: assert property (
        (setup_end && q.op == OP_PROG) |=> core_stall ##1 flash_wr_en)
        else $error("program did not start after final latch load");
    a_prog_no_erase: assert property (
        (q.st == ST_PROG || q.st == ST_WAIT) |-> !flash_erase_en)
        else $error("erase issued during program");
    a_block_bound: assert property (
        flash_wr_en |-> (flash_addr[ADDR_W-1:LAT_BITS] == q.base))
        else $error("program crossed latch block boundary");
    a_word_count: assert property (
        (q.st == ST_WAIT && $past(q.st) == ST_PROG) |-> ($past(q.idx) == LAT_BITS'(LATCHES - 1)))
        else $error("program wrote a wrong number of words");

    c_erase: cover property ($fell(core_stall) && $past(q.st) == ST_ERASE);
    c_load: cover property (setup_end && q.op == OP_LOAD);
    c_prog: cover property (clr_all);
endmodule : fsp_sequencer

// file: include/fsp_pkg.sv
/*
 * shared constants and types of the flash self-program sequencer:
 * unlock keys, erased word value, timing figures and state codes.
 * assumes a 10 MHz system clock feeding every block that imports it.
 */
package fsp_pkg;
    // ------------------------------------------------------------
    // widths and values
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 14;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int ERASE_TIME_MS = 2;
    // typical figure, rounded down to whole cycles
    localparam int ERASE_CYCLES_DEF = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int PROG_CYCLES_DEF = 20000;
    localparam int SETUP_CYCLES = 2;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [1:0] KEY_NONE = 2'h0;
    localparam logic [1:0] KEY_HALF = 2'h1;
    localparam logic [1:0] KEY_BOTH = 2'h2;
    localparam logic [1:0] OP_LOAD = 2'h0;
    localparam logic [1:0] OP_ERASE = 2'h1;
    localparam logic [1:0] OP_PROG = 2'h2;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SETUP = 5'h02,
        ST_ERASE = 5'h04,
        ST_PROG = 5'h08,
        ST_WAIT = 5'h10
    } fsp_state_t;
endpackage : fsp_pkg
